// ### hw/rxes_top.sv
// receive elastic slip buffer with clock source selection and wishbone registers
// Notes on behaviour
// - received bits pass through a first-in first-out elastic store that fills and drains.
// - the store is written on satellite clock edges and read on the selected output clock.
// - a slip is flagged when a write finds the store totally full or a read finds it totally empty.
// - overflow and underflow slips are counted apart and both counts are readable.
// - with the satellite clock as output source the store is bypassed.
// - the transmit clock comes from the transmit clock input or the output clock.
// - the internal source makes the output clock here and drives it out with the data.
// - the output clock may also come from the transmit clock input or station clock.
// - depth is set in milliseconds, up to sixteen.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module rxes_top
  import rxes_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // satellite receive side pins
  input  wire logic        sat_clk_i,
  input  wire logic        sat_data_i,
  // terrestrial clock pins
  input  wire logic        tx_clk_in_i,
  input  wire logic        station_clk_i,
  // terrestrial outputs
  output logic             terr_clk_o,
  output logic             terr_data_o,
  output logic             tx_clk_o,
  // interrupt
  output logic             irq_o
);
  localparam int NSYNC = 4;

  rxes_cfg_t          cfg_q;
  logic [1:0]         mask_q, stat_q;
  logic [15:0]        over_cnt_q, under_cnt_q;
  logic [NSYNC-1:0]   pin_vec, sync1_q, sync2_q;
  logic               sclk_prev_q, oclk_prev_q;
  logic [15:0]        div_cnt_q;
  logic               int_clk_q;
  logic               oclk, bypass, active;
  logic               wr_ev, rd_ev, over_slip, under_slip;
  logic [16:0]        prod;
  logic [15:0]        depth_d, depth_q, half, fill_q;
  logic [RXES_AW-1:0] wp_q, rp_q, rp_ctr;
  logic               rd_pend_q, mem_q_bit, active_q;
  rxes_wr_t           wr;
  logic               bus_req, bus_wr;
  logic [31:0]        rd_d;

  // byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // pointer step with wrap at the configured depth
  function automatic logic [RXES_AW-1:0] ptr_inc(input logic [RXES_AW-1:0] p,
                                                 input logic [15:0]        d);
    logic [RXES_AW-1:0] r;
    r = (16'(p) == d - 16'h0001) ? '0 : p + 1'b1;
    return r;
  endfunction

  // two-flop synchronisers for every pin from outside the clock domain
  assign pin_vec = {station_clk_i, tx_clk_in_i, sat_data_i, sat_clk_i};
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1_q[g] <= 1'b0;
        sync2_q[g] <= 1'b0;
      end else begin
        sync1_q[g] <= pin_vec[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  // wishbone handshake: ack one cycle after the request, dropped the cycle after
  assign bus_req = cyc_i & stb_i;
  assign bus_wr  = bus_req & we_i & ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req & ~ack_o;
    end
  end

  // read mux of the register file, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (adr_i)
      RXES_CTRL_OFS:  rd_d = {28'h0, cfg_q.rx_sel, cfg_q.tx_sel, cfg_q.en};
      RXES_DEPTH_OFS: rd_d = {27'h0, cfg_q.depth_ms};
      RXES_RATE_OFS:  rd_d = {20'h0, cfg_q.rate_kbps};
      RXES_DIV_OFS:   rd_d = {16'h0, cfg_q.div};
      RXES_STAT_OFS:  rd_d = {30'h0, stat_q};
      RXES_MASK_OFS:  rd_d = {30'h0, mask_q};
      RXES_OVER_OFS:  rd_d = {16'h0, over_cnt_q};
      RXES_UNDER_OFS: rd_d = {16'h0, under_cnt_q};
      RXES_FILL_OFS:  rd_d = {16'h0, fill_q};
      default:        rd_d = 32'h0000_0000;
    endcase
  end

  // read data register, loaded as ack rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req & ~ack_o) begin
      dat_o <= rd_d;
    end
  end

  // configuration registers, written at the edge where ack is seen
  always_ff @(posedge clk_i) begin
    logic [31:0] v;
    v = 32'h0000_0000;
    if (rst_i) begin
      cfg_q  <= RXES_CFG_RST;
      mask_q <= RXES_MASK_RST;
    end else if (bus_wr) begin
      case (adr_i)
        RXES_CTRL_OFS: begin
          v = be_merge({28'h0, cfg_q.rx_sel, cfg_q.tx_sel, cfg_q.en}, dat_i, sel_i);
          cfg_q.en     <= v[RXES_CTRL_EN_BIT];
          cfg_q.tx_sel <= v[RXES_CTRL_TX_BIT];
          cfg_q.rx_sel <= v[RXES_CTRL_RX_LSB +: 2];
        end
        RXES_DEPTH_OFS: begin
          v = be_merge({27'h0, cfg_q.depth_ms}, dat_i, sel_i);
          cfg_q.depth_ms <= (v[4:0] > RXES_MAX_MS) ? RXES_MAX_MS : v[4:0];
        end
        RXES_RATE_OFS: begin
          v = be_merge({20'h0, cfg_q.rate_kbps}, dat_i, sel_i);
          cfg_q.rate_kbps <= v[11:0];
        end
        RXES_DIV_OFS: begin
          v = be_merge({16'h0, cfg_q.div}, dat_i, sel_i);
          cfg_q.div <= (v[15:0] == 16'h0000) ? 16'h0001 : v[15:0];
        end
        RXES_MASK_OFS: begin
          v = be_merge({30'h0, mask_q}, dat_i, sel_i);
          mask_q <= v[1:0];
        end
        default: v = 32'h0000_0000;
      endcase
    end
  end

  // internal output clock generator, half period set by the divider register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_q <= 16'h0000;
      int_clk_q <= 1'b0;
    end else if (div_cnt_q >= cfg_q.div - 16'h0001) begin
      div_cnt_q <= 16'h0000;
      int_clk_q <= ~int_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // output clock source selection
  always_comb begin
    case (cfg_q.rx_sel)
      RXES_RX_SAT:  oclk = sync2_q[0];
      RXES_RX_INT:  oclk = int_clk_q;
      RXES_RX_TXIN: oclk = sync2_q[2];
      RXES_RX_STN:  oclk = sync2_q[3];
      default:      oclk = int_clk_q;
    endcase
  end

  // edge detection on the satellite clock and the selected output clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      oclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sync2_q[0];
      oclk_prev_q <= oclk;
    end
  end

  assign bypass = (cfg_q.rx_sel == RXES_RX_SAT);
  assign active = cfg_q.en & ~bypass;
  assign wr_ev  = active & sync2_q[0] & ~sclk_prev_q;
  assign rd_ev  = active & oclk & ~oclk_prev_q;

  // depth in bits from milliseconds and rate, clamped to the storage
  assign prod = 17'(cfg_q.depth_ms * cfg_q.rate_kbps);
  always_comb begin
    if (prod > 17'(RXES_MEM_DEPTH)) begin
      depth_d = 16'(RXES_MEM_DEPTH);
    end else if (prod < RXES_MIN_BITS) begin
      depth_d = 16'(RXES_MIN_BITS);
    end else begin
      depth_d = prod[15:0];
    end
  end
  assign half = {1'b0, depth_q[15:1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_q <= 16'(RXES_MIN_BITS);
    end else begin
      depth_q <= depth_d;
    end
  end

  // slip detection: full on a write, empty on a read
  assign over_slip  = wr_ev & ~rd_ev & (fill_q >= depth_q);
  assign under_slip = rd_ev & ~wr_ev & (fill_q == 16'h0000);

  // read pointer placed half a store behind the write pointer
  always_comb begin
    if (16'(wp_q) >= half) begin
      rp_ctr = wp_q - half[RXES_AW-1:0];
    end else begin
      rp_ctr = RXES_AW'(16'(wp_q) + depth_q - half);
    end
  end

  // pointers and fill level of the elastic store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q     <= '0;
      rp_q     <= '0;
      fill_q   <= 16'h0000;
      active_q <= 1'b0;
    end else begin
      active_q <= active;
      if (!active || !active_q) begin
        wp_q   <= half[RXES_AW-1:0];
        rp_q   <= '0;
        fill_q <= half;
      end else if (over_slip || under_slip) begin
        rp_q   <= rp_ctr;
        fill_q <= half;
      end else begin
        if (wr_ev) begin
          wp_q <= ptr_inc(wp_q, depth_q);
        end
        if (rd_ev) begin
          rp_q <= ptr_inc(rp_q, depth_q);
        end
        if (wr_ev && !rd_ev) begin
          fill_q <= fill_q + 16'h0001;
        end else if (rd_ev && !wr_ev) begin
          fill_q <= fill_q - 16'h0001;
        end
      end
    end
  end

  // storage write request, dropped on an overflow slip
  assign wr.en   = wr_ev & ~over_slip & active_q;
  assign wr.addr = wp_q;
  assign wr.data = sync2_q[1];

  rxes_mem u_mem (
    .clk_i     (clk_i),
    .wr_i      (wr),
    .rd_addr_i (rp_q),
    .rd_data_o (mem_q_bit)
  );

  // read pending flag, storage data valid one cycle after a read edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_ev & ~under_slip & active_q;
    end
  end

  // terrestrial data and clock outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      terr_data_o <= 1'b0;
      terr_clk_o  <= 1'b0;
    end else begin
      terr_clk_o <= oclk_prev_q;
      if (bypass) begin
        terr_data_o <= sync2_q[1];
      end else if (rd_pend_q) begin
        terr_data_o <= mem_q_bit;
      end
    end
  end

  // transmit clock source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_clk_o <= 1'b0;
    end else if (cfg_q.tx_sel == RXES_TX_RXOUT) begin
      tx_clk_o <= oclk_prev_q;
    end else begin
      tx_clk_o <= sync2_q[2];
    end
  end

  // slip counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_cnt_q  <= 16'h0000;
      under_cnt_q <= 16'h0000;
    end else begin
      if (over_slip && active_q) begin
        over_cnt_q <= over_cnt_q + 16'h0001;
      end
      if (under_slip && active_q) begin
        under_cnt_q <= under_cnt_q + 16'h0001;
      end
    end
  end

  // sticky slip status, write one to clear, a new slip wins over the clear
  always_ff @(posedge clk_i) begin
    logic [1:0] clr, set;
    clr = (bus_wr && adr_i == RXES_STAT_OFS && sel_i[0]) ? dat_i[1:0] : 2'h0;
    set = 2'h0;
    set[RXES_STAT_OVER_BIT]  = over_slip & active_q;
    set[RXES_STAT_UNDER_BIT] = under_slip & active_q;
    if (rst_i) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~clr) | set;
    end
  end

  // interrupt level from unmasked status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_q & mask_q);
    end
  end
endmodule

// ### hw/rxes_pkg.sv
// constants, field layouts and carrier types of the receive elastic slip buffer
package rxes_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] RXES_CTRL_OFS  = 8'h00;
  localparam logic [7:0] RXES_DEPTH_OFS = 8'h04;
  localparam logic [7:0] RXES_RATE_OFS  = 8'h08;
  localparam logic [7:0] RXES_DIV_OFS   = 8'h0C;
  localparam logic [7:0] RXES_STAT_OFS  = 8'h10;
  localparam logic [7:0] RXES_MASK_OFS  = 8'h14;
  localparam logic [7:0] RXES_OVER_OFS  = 8'h18;
  localparam logic [7:0] RXES_UNDER_OFS = 8'h1C;
  localparam logic [7:0] RXES_FILL_OFS  = 8'h20;
  // control field positions
  localparam int RXES_CTRL_EN_BIT = 0;
  localparam int RXES_CTRL_TX_BIT = 1;
  localparam int RXES_CTRL_RX_LSB = 2;
  // status and mask field positions
  localparam int RXES_STAT_OVER_BIT  = 0;
  localparam int RXES_STAT_UNDER_BIT = 1;
  // receive output clock sources
  localparam logic [1:0] RXES_RX_SAT  = 2'h0;
  localparam logic [1:0] RXES_RX_INT  = 2'h1;
  localparam logic [1:0] RXES_RX_TXIN = 2'h2;
  localparam logic [1:0] RXES_RX_STN  = 2'h3;
  // transmit clock sources
  localparam logic RXES_TX_TXIN = 1'b0;
  localparam logic RXES_TX_RXOUT = 1'b1;
  // store geometry
  localparam int          RXES_AW        = 15;
  localparam int          RXES_MEM_DEPTH = 32768;
  localparam logic [4:0]  RXES_MAX_MS    = 5'h10;
  localparam logic [16:0] RXES_MIN_BITS  = 17'h00002;
  // clock and internal output clock timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int INT_CLK_KHZ_DEF = 2048;
  localparam int INT_HALF_CYC    = CLK_HZ / (INT_CLK_KHZ_DEF * 2000);
  // reset values
  localparam logic [4:0]  RXES_DEPTH_RST = 5'h02;
  localparam logic [11:0] RXES_RATE_RST  = 12'h800;
  localparam logic [15:0] RXES_DIV_RST   = 16'(INT_HALF_CYC);
  localparam logic [1:0]  RXES_MASK_RST  = 2'h0;
  // software configuration carrier
  typedef struct packed {
    logic        en;
    logic        tx_sel;
    logic [1:0]  rx_sel;
    logic [4:0]  depth_ms;
    logic [11:0] rate_kbps;
    logic [15:0] div;
  } rxes_cfg_t;
  localparam rxes_cfg_t RXES_CFG_RST = '{1'b0, RXES_TX_TXIN, RXES_RX_INT,
                                         RXES_DEPTH_RST, RXES_RATE_RST, RXES_DIV_RST};
  // store write request carrier
  typedef struct packed {
    logic               en;
    logic [RXES_AW-1:0] addr;
    logic               data;
  } rxes_wr_t;
endpackage

// ### hw/rxes_mem.sv
// single-bit dual-port storage of the elastic store with registered read data
`timescale 1ns/10ps
module rxes_mem
  import rxes_pkg::*;
(
  // clock
  input  wire logic               clk_i,
  // write port
  input  wire rxes_wr_t           wr_i,
  // read port
  input  wire logic [RXES_AW-1:0] rd_addr_i,
  output logic                    rd_data_o
);
  logic mem_q [RXES_MEM_DEPTH];

  // write port
  always_ff @(posedge clk_i) begin
    if (wr_i.en) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  // registered read port
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

// ### sim/rxes_partner.sv
// satellite demodulator and terrestrial clock sources facing the buffer
`timescale 1ns/10ps
module rxes_partner (
  // frame control
  input  wire logic run_i,
  // satellite side
  output logic      sat_clk_o,
  output logic      sat_data_o,
  // terrestrial clocks
  output logic      tx_clk_in_o,
  output logic      station_clk_o
);
  // recovered clock stops low between frames; the idle data line keeps toggling
  initial begin
    sat_clk_o  = 1'b0;
    sat_data_o = 1'b0;
    #13;
    forever begin
      #100;
      if (run_i || sat_clk_o) sat_clk_o = ~sat_clk_o;
      if (!sat_clk_o) sat_data_o = run_i ? 1'($urandom) : ~sat_data_o;
    end
  end
  // free-running network and station clocks, phases unrelated to the system clock
  initial begin
    station_clk_o = 1'b0;
    #37;
    forever #100 station_clk_o = ~station_clk_o;
  end
  initial begin
    tx_clk_in_o = 1'b0;
    #71;
    forever #100 tx_clk_in_o = ~tx_clk_in_o;
  end
endmodule

// ### sim/rxes_top_asserts.sv
// port checker for the receive elastic slip buffer
`timescale 1ns/10ps
module rxes_top_asserts
  import rxes_pkg::*;
(
  // clock, reset and bus
  input wire logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic [3:0]  sel_i,
  // link pins
  input wire logic        sat_clk_i, sat_data_i, tx_clk_in_i, station_clk_i,
  input wire logic        terr_clk_o, terr_data_o, tx_clk_o, irq_o
);
  logic [3:0] ctl_q;
  logic [5:0] age_q;
  logic       live;
  // control shadow and quiet time since the last register write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= {RXES_RX_INT, RXES_TX_TXIN, 1'b0};
      age_q <= 6'h00;
    end else if (ack_o && we_i) begin
      if (sel_i[0] && adr_i == RXES_CTRL_OFS) ctl_q <= dat_i[3:0];
      age_q <= 6'h00;
    end else if (age_q != 6'h3F) begin
      age_q <= age_q + 6'h01;
    end
  end
  assign live = ctl_q[0] && age_q == 6'h3F;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one: assert property (ack_o |=> !ack_o) else $error("ack wider than a cycle");
  chk_ack_turn: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  chk_rd_hold: assert property ($changed(dat_o) |-> ack_o) else $error("read data moved");
  chk_byp_clk: assert property (live && ctl_q[3:2] == RXES_RX_SAT && $rose(sat_clk_i)
    |-> ##[1:5] $rose(terr_clk_o)) else $error("bypass clock not followed");
  chk_stn_src: assert property (live && ctl_q[3:2] == RXES_RX_STN && $rose(station_clk_i)
    |-> ##[1:5] $rose(terr_clk_o)) else $error("station clock not followed");
  chk_pin_src: assert property (live && ctl_q[3:2] == RXES_RX_TXIN && $rose(tx_clk_in_i)
    |-> ##[1:5] $rose(terr_clk_o)) else $error("tx input clock not followed");
  chk_tx_pin: assert property (live && ctl_q[1] == RXES_TX_TXIN && $rose(tx_clk_in_i)
    |-> ##[1:5] $rose(tx_clk_o)) else $error("tx clock not from input");
  chk_tx_loop: assert property (live && ctl_q[1] == RXES_TX_RXOUT && $rose(terr_clk_o)
    |-> ##[0:3] $rose(tx_clk_o)) else $error("tx clock not from output clock");
  chk_int_half: assert property (live && ctl_q[3:2] == RXES_RX_INT && $changed(terr_clk_o)
    |=> $stable(terr_clk_o)[*8] ##[1:3] $changed(terr_clk_o)) else $error("internal clock period");
  // buffered data is launched at the same edge as the output clock rises
  chk_dat_step: assert property (live && ctl_q[3:2] != RXES_RX_SAT && $changed(terr_data_o)
    |-> $rose(terr_clk_o)) else $error("data moved off output clock");
  cov_bypass: cover property (live && ctl_q[3:2] == RXES_RX_SAT && $rose(terr_clk_o));
  cov_irq: cover property ($rose(irq_o));
  cov_loop: cover property (live && ctl_q[1] == RXES_TX_RXOUT && $rose(tx_clk_o));
endmodule
bind rxes_top rxes_top_asserts rxes_top_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .sat_clk_i(sat_clk_i),
  .sat_data_i(sat_data_i), .tx_clk_in_i(tx_clk_in_i), .station_clk_i(station_clk_i),
  .terr_clk_o(terr_clk_o), .terr_data_o(terr_data_o), .tx_clk_o(tx_clk_o), .irq_o(irq_o));

// ### sim/tb_rxes_top.sv
// self-checking bench for the receive elastic slip buffer
`timescale 1ns/10ps
module tb_rxes_top;
  import rxes_pkg::*;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, run, logon, tc_q;
  logic        sat_clk, sat_data, tx_in, stn, terr_clk_o, terr_data_o, tx_clk_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q, v;
  logic        inq[$];
  logic        outq[$];
  int          errors, checked, ms, kb, half;
  // system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  rxes_top rxes_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .sat_clk_i(sat_clk), .sat_data_i(sat_data), .tx_clk_in_i(tx_in), .station_clk_i(stn),
    .terr_clk_o(terr_clk_o), .terr_data_o(terr_data_o), .tx_clk_o(tx_clk_o), .irq_o(irq_o));
  rxes_partner rxes_partner_inst (.run_i(run), .sat_clk_o(sat_clk), .sat_data_o(sat_data),
    .tx_clk_in_o(tx_in), .station_clk_o(stn));
  // capture bits entering on the satellite clock and leaving on the output clock
  always @(posedge sat_clk) if (logon) inq.push_back(sat_data);
  always @(posedge clk_i) begin
    tc_q <= terr_clk_o;
    if (logon && terr_clk_o && !tc_q) outq.push_back(terr_data_o);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask
  function automatic int bits(int m, int r);
    int b;
    b = m * r;
    if (b < int'(RXES_MIN_BITS)) b = int'(RXES_MIN_BITS);
    if (b > RXES_MEM_DEPTH) b = RXES_MEM_DEPTH;
    return b;
  endfunction
  // output stream equals the input stream delayed by about e bits
  function automatic bit in_order(int e);
    for (int d = e - 2; d <= e + 2; d++) begin
      bit ok;
      ok = 1'b1;
      for (int i = 3; i < 19; i++) if (outq[i + d] !== inq[i]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end
  initial begin
    void'($urandom(78110));
    {rst_i, cyc_i, stb_i, we_i, run, logon} = 6'h20;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped slot
    rd(RXES_CTRL_OFS, 32'h4, "ctrl");
    rd(RXES_DEPTH_OFS, 32'(RXES_DEPTH_RST), "depth");
    rd(RXES_RATE_OFS, 32'(RXES_RATE_RST), "rate");
    rd(RXES_DIV_OFS, 32'(RXES_DIV_RST), "div");
    for (int i = 0; i < 4; i++) rd(RXES_STAT_OFS + 8'(4 * i), 32'h0, "zero reg");
    // idle store sits centred on the reset depth
    rd(RXES_FILL_OFS, 32'(bits(int'(RXES_DEPTH_RST), int'(RXES_RATE_RST)) / 2), "fill idle");
    rd(8'h24, 32'h0, "unmapped");
    // random and boundary register values, writes to read-only and unmapped places
    for (int i = 0; i < 6; i++) begin
      v = i < 2 ? 32'(16 + i) : $urandom;
      wb(1'b1, RXES_DEPTH_OFS, v);
      rd(RXES_DEPTH_OFS, v[4:0] > RXES_MAX_MS ? 32'(RXES_MAX_MS) : 32'(v[4:0]), "ms");
      wb(1'b1, RXES_RATE_OFS, v);
      rd(RXES_RATE_OFS, 32'(v[11:0]), "rate");
      wb(1'b1, RXES_DIV_OFS, i == 0 ? 32'h0 : v);
      rd(RXES_DIV_OFS, i == 0 ? 32'h1 : 32'(v[15:0]), "div");
      wb(1'b1, RXES_UNDER_OFS - 8'(4 * (i % 2)), v);
      wb(1'b1, 8'h24, v);
      rd(RXES_UNDER_OFS - 8'(4 * (i % 2)), 32'h0, "count read only");
    end
    // a write with no byte lane enabled leaves the register alone
    sel_i <= 4'h0;
    wb(1'b1, RXES_DIV_OFS, 32'(RXES_DIV_RST));
    sel_i <= 4'hF;
    rd(RXES_DIV_OFS, 32'(v[15:0]), "div no lanes");
    wb(1'b1, RXES_DIV_OFS, 32'(RXES_DIV_RST));
    // stream through bypass, station and tx input clocked store
    run <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      ms = m == 1 ? 4 : 1 + $urandom_range(2); // four ms for a doubled hop
      kb = 4 + $urandom_range(12);
      half = bits(ms, kb) / 2;
      wb(1'b1, RXES_DEPTH_OFS, 32'(ms));
      wb(1'b1, RXES_RATE_OFS, 32'(kb));
      wb(1'b1, RXES_CTRL_OFS, {28'h0, m == 0 ? RXES_RX_SAT : m == 1 ? RXES_RX_STN : RXES_RX_TXIN,
                               m == 0, 1'b1});
      wb(1'b0, RXES_FILL_OFS, 32'h0);
      chk("fill at enable", 32'(q + 1 - half <= 2), 32'h1);
      logon <= 1'b1;
      while (outq.size() < half + 24) @(posedge clk_i);
      logon <= 1'b0;
      chk("stream order", 32'(in_order(m == 0 ? 0 : half + 1)), 32'h1);
      inq.delete();
      outq.delete();
      rd(RXES_STAT_OFS, 32'h0, "no slip");
      wb(1'b1, RXES_CTRL_OFS, 32'h0);
    end
    // internal clock slower than the satellite: overflow slips
    wb(1'b1, RXES_DEPTH_OFS, 32'h1);
    wb(1'b1, RXES_RATE_OFS, 32'h8);
    wb(1'b1, RXES_MASK_OFS, 32'h2);
    wb(1'b1, RXES_CTRL_OFS, {28'h0, RXES_RX_INT, RXES_TX_TXIN, 1'b1});
    repeat (400) @(posedge clk_i);
    wb(1'b0, RXES_STAT_OFS, 32'h0);
    chk("overflow flag", q & 32'h3, 32'h1);
    chk("irq masked", 32'(irq_o), 32'h0);
    rd(RXES_UNDER_OFS, 32'h0, "no underflow");
    // satellite stops between frames: store drains and underflows
    run <= 1'b0;
    // let a last satellite edge clear the synchronisers before the count is taken
    repeat (8) @(posedge clk_i);
    wb(1'b0, RXES_OVER_OFS, 32'h0);
    v = q;
    chk("overflow counted", 32'(v != 0), 32'h1);
    repeat (400) @(posedge clk_i);
    rd(RXES_OVER_OFS, v, "overflow count held");
    wb(1'b0, RXES_UNDER_OFS, 32'h0);
    chk("underflow counted", 32'(q != 0), 32'h1);
    rd(RXES_STAT_OFS, 32'h3, "both flags");
    chk("irq raised", 32'(irq_o), 32'h1);
    wb(1'b1, RXES_STAT_OFS, 32'h1);
    rd(RXES_STAT_OFS, 32'h2, "overflow cleared");
    wb(1'b1, RXES_MASK_OFS, 32'h1);
    rd(RXES_MASK_OFS, 32'h1, "mask");
    chk("irq masked off", 32'(irq_o), 32'h0);
    run <= 1'b1;
    wb(1'b1, RXES_CTRL_OFS, 32'h0);
    wb(1'b1, RXES_STAT_OFS, 32'h3);
    rd(RXES_STAT_OFS, 32'h0, "flags cleared");
    end_sim();
  end
endmodule
